// ---- verilog/lcs_pkg.sv ----
// Purpose: Shared constants of the loop control supervisor.
// Assumes: Percent values in 0.1 % steps, frequencies in 0.01 Hz steps.
// Notes:   Register offsets are byte addresses on the AXI4-Lite slave.
`default_nettype none
package lcs_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_MODE    = 8'h00;
  localparam logic [7:0] ADDR_INSEL   = 8'h04;
  localparam logic [7:0] ADDR_OUTSEL  = 8'h0C;
  localparam logic [7:0] ADDR_UPPER   = 8'h14;
  localparam logic [7:0] ADDR_LOWER   = 8'h18;
  localparam logic [7:0] ADDR_SWITCH  = 8'h1C;
  localparam logic [7:0] ADDR_GAIN    = 8'h20;
  localparam logic [7:0] ADDR_BIAS    = 8'h24;
  localparam logic [7:0] ADDR_DISPSEL = 8'h28;
  localparam logic [7:0] ADDR_STATUS  = 8'h2C;
  localparam logic [7:0] ADDR_MONITOR = 8'h30;
  localparam logic [7:0] ADDR_FREQ    = 8'h34;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;
  // ----------------------------------------------------------------
  // Mode and function codes
  // ----------------------------------------------------------------
  localparam logic [7:0] LAS_OFF      = 8'h00;
  localparam logic [7:0] LAS_DEV_A    = 8'h32;
  localparam logic [7:0] LAS_DEV_B    = 8'h33;
  localparam logic [7:0] LAS_SPMV_A   = 8'h3C;
  localparam logic [7:0] LAS_SPMV_B   = 8'h3D;
  localparam logic [7:0] FN_LOOP_EN   = 8'h0E;
  localparam logic [7:0] FN_LOWER     = 8'h0E;
  localparam logic [7:0] FN_UPPER     = 8'h0F;
  localparam logic [7:0] FN_DIR       = 8'h10;
  localparam logic [7:0] FN_ACTIVE    = 8'h2F;
  localparam logic [7:0] FN_NEG_BASE  = 8'h64;
  localparam logic [7:0] SEL_NONE     = 8'h63;
  localparam logic [7:0] MON_SP       = 8'h34;
  localparam logic [7:0] MON_MV       = 8'h35;
  localparam logic [7:0] MON_DEV      = 8'h36;
  // ----------------------------------------------------------------
  // Values and reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] NO_FUNC      = 16'h270F;
  localparam logic [15:0] SW_MAX       = 16'h9C40;
  localparam logic [15:0] FULL_DEV     = 16'h03E8;
  localparam logic [15:0] DEV_OFFSET   = 16'h03E8;
  localparam logic signed [28:0] FULL_DEV_W = 29'sh00003E8;
  localparam logic [15:0] GAIN_RST     = 16'h1770;
  localparam logic [15:0] BIAS_RST     = 16'h0000;
  localparam logic [7:0]  DISP_RST     = 8'h00;
  // ----------------------------------------------------------------
  // Switchover states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_START = 3'b010,
    ST_LOOP  = 3'b100
  } lcs_state_t;
endpackage : lcs_pkg
`default_nettype wire

// ---- verilog/lcs_out_term.sv ----
// Purpose: One output terminal with function select and negative logic.
// Assumes: Level inputs are valid in the cycle they are sampled.
// Notes:   Output follows the chosen level one clock later.
`timescale 1ns/1ps
`default_nettype none
module lcs_out_term (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       srst,
  // Function select
  input  wire logic [7:0] sel,
  // Candidate levels
  input  wire logic       upper_lvl,
  input  wire logic       lower_lvl,
  input  wire logic       dir_lvl,
  input  wire logic       active_lvl,
  // Terminal
  output logic            out_q
);
  logic       neg;
  logic [7:0] base;
  logic       lvl;
  logic       out_d;

  // ----------------------------------------------------------------
  // Function decode
  // ----------------------------------------------------------------
  always_comb begin
    neg  = (sel >= lcs_pkg::FN_NEG_BASE);
    base = neg ? 8'(sel - lcs_pkg::FN_NEG_BASE) : sel;
    lvl  = 1'b0;
    if (base == lcs_pkg::FN_UPPER) lvl = upper_lvl;
    if (base == lcs_pkg::FN_LOWER) lvl = lower_lvl;
    if (base == lcs_pkg::FN_DIR) lvl = dir_lvl;
    if (base == lcs_pkg::FN_ACTIVE) lvl = active_lvl;
    out_d = lvl ^ neg;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      out_q <= 1'b0;
    end else begin
      out_q <= out_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_NEG_ACTIVE: assert property (@(posedge clock) disable iff (srst)
    (sel == 8'(lcs_pkg::FN_ACTIVE + lcs_pkg::FN_NEG_BASE)) |=> (out_q == !$past(active_lvl)))
    else $error("Inverted loop-active terminal wrong.");
  AST_DIR_OUT: assert property (@(posedge clock) disable iff (srst)
    (sel == lcs_pkg::FN_DIR) |=> (out_q == $past(dir_lvl)))
    else $error("Direction terminal wrong.");
endmodule : lcs_out_term
`default_nettype wire

// ---- verilog/lcs_top.sv ----
// Purpose: Supervisor around a drive's closed loop frequency controller.
// Assumes: Fieldbus values and pins are synchronous to clock.
// Notes:   Registers on an AXI4-Lite slave; outputs all registered.
//
// Added by the designer: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module lcs_top #(
  parameter int N_IN  = 5,
  parameter int N_OUT = 6
) (
  // Clock and reset
  input  wire logic               clock,
  input  wire logic               srst,
  // AXI4-Lite write
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  // Fieldbus master values
  input  wire logic [15:0]        fb_set_point,
  input  wire logic [15:0]        fb_measured,
  input  wire logic signed [15:0] fb_deviation,
  input  wire logic [N_IN-1:0]    fb_vterm,
  // Drive state and input terminals
  input  wire logic [N_IN-1:0]    in_pin,
  input  wire logic               run,
  input  wire logic               fwd,
  input  wire logic [15:0]        out_freq,
  // Results
  output logic [N_OUT-1:0]        out_term_q,
  output logic                    loop_active_q,
  output logic [15:0]             freq_cmd_q,
  output logic [15:0]             monitor_q
);
  if (N_IN < 1 || N_IN > 8 || N_OUT < 1 || N_OUT > 8) begin : g_bad
    $error("N_IN and N_OUT must lie in 1 to 8.");
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [7:0]  las_q, las_d, disp_q, disp_d;
  logic [7:0]  insel_q [N_IN];
  logic [7:0]  insel_d [N_IN];
  logic [7:0]  outsel_q [N_OUT];
  logic [7:0]  outsel_d [N_OUT];
  logic [15:0] upper_q, upper_d, lower_q, lower_d, sw_q, sw_d, gain_q, gain_d, bias_q, bias_d;
  // AXI state
  logic        aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [7:0]  aw_addr_q, aw_addr_d;
  logic [31:0] w_data_q, w_data_d;
  logic [3:0]  w_strb_q, w_strb_d;
  logic        awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
  logic [1:0]  bresp_d, rresp_d;
  logic [31:0] rdata_d;
  logic        wr_en, wr_hit;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
    logic [15:0] res;
    res = old;
    if (strb[0]) res[7:0] = data[7:0];
    if (strb[1]) res[15:8] = data[15:8];
    return res;
  endfunction : merge16

  // ----------------------------------------------------------------
  // Loop logic signals
  // ----------------------------------------------------------------
  lcs_pkg::lcs_state_t state_q, state_d;
  logic                assigned, enable_lvl, mode_dev, mode_spmv, want, sw_on;
  logic signed [16:0]  dev;
  logic [15:0]         devc, mon_d, freq_d;
  logic signed [16:0]  span;
  logic signed [28:0]  quot;
  logic                upper_lvl, lower_lvl;

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  always_comb begin
    wr_en     = aw_have_q && w_have_q && !s_axi_bvalid;
    aw_have_d = aw_have_q;
    aw_addr_d = aw_addr_q;
    w_have_d  = w_have_q;
    w_data_d  = w_data_q;
    w_strb_d  = w_strb_q;
    bvalid_d  = s_axi_bvalid;
    bresp_d   = s_axi_bresp;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_have_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_have_d = 1'b1;
      w_data_d = s_axi_wdata;
      w_strb_d = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) bvalid_d = 1'b0;
    if (wr_en) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = wr_hit ? lcs_pkg::RESP_OKAY : lcs_pkg::RESP_SLVERR;
    end
    awready_d = !aw_have_d && !bvalid_d;
    wready_d  = !w_have_d && !bvalid_d;
    rvalid_d  = s_axi_rvalid;
    rdata_d   = s_axi_rdata;
    rresp_d   = s_axi_rresp;
    if (s_axi_rvalid && s_axi_rready) rvalid_d = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d  = lcs_pkg::RESP_OKAY;
      rdata_d  = 32'h0000_0000;
      unique case (s_axi_araddr)
        lcs_pkg::ADDR_MODE:    rdata_d[7:0] = las_q;
        lcs_pkg::ADDR_UPPER:   rdata_d[15:0] = upper_q;
        lcs_pkg::ADDR_LOWER:   rdata_d[15:0] = lower_q;
        lcs_pkg::ADDR_SWITCH:  rdata_d[15:0] = sw_q;
        lcs_pkg::ADDR_GAIN:    rdata_d[15:0] = gain_q;
        lcs_pkg::ADDR_BIAS:    rdata_d[15:0] = bias_q;
        lcs_pkg::ADDR_DISPSEL: rdata_d[7:0] = disp_q;
        lcs_pkg::ADDR_STATUS:  rdata_d[5:0] = {upper_lvl, lower_lvl, state_q, loop_active_q};
        lcs_pkg::ADDR_MONITOR: rdata_d[15:0] = monitor_q;
        lcs_pkg::ADDR_FREQ:    rdata_d[15:0] = freq_cmd_q;
        default: begin
          rresp_d = lcs_pkg::RESP_SLVERR;
          for (int i = 0; i < N_IN; i++) begin
            if (s_axi_araddr == 8'(lcs_pkg::ADDR_INSEL + 8'(4 * (i / 4)))) begin
              rresp_d = lcs_pkg::RESP_OKAY;
              rdata_d[8*(i%4) +: 8] = insel_q[i];
            end
          end
          for (int i = 0; i < N_OUT; i++) begin
            if (s_axi_araddr == 8'(lcs_pkg::ADDR_OUTSEL + 8'(4 * (i / 4)))) begin
              rresp_d = lcs_pkg::RESP_OKAY;
              rdata_d[8*(i%4) +: 8] = outsel_q[i];
            end
          end
        end
      endcase
    end
    arready_d = !rvalid_d;
  end

  // Register writes.
  always_comb begin
    las_d   = las_q;
    disp_d  = disp_q;
    upper_d = upper_q;
    lower_d = lower_q;
    sw_d    = sw_q;
    gain_d  = gain_q;
    bias_d  = bias_q;
    insel_d  = insel_q;
    outsel_d = outsel_q;
    wr_hit  = 1'b1;
    unique case (aw_addr_q)
      lcs_pkg::ADDR_MODE:    if (wr_en && w_strb_q[0]) las_d = w_data_q[7:0];
      lcs_pkg::ADDR_UPPER:   if (wr_en) upper_d = merge16(upper_q, w_data_q, w_strb_q);
      lcs_pkg::ADDR_LOWER:   if (wr_en) lower_d = merge16(lower_q, w_data_q, w_strb_q);
      lcs_pkg::ADDR_SWITCH:  if (wr_en) sw_d = merge16(sw_q, w_data_q, w_strb_q);
      lcs_pkg::ADDR_GAIN:    if (wr_en) gain_d = merge16(gain_q, w_data_q, w_strb_q);
      lcs_pkg::ADDR_BIAS:    if (wr_en) bias_d = merge16(bias_q, w_data_q, w_strb_q);
      lcs_pkg::ADDR_DISPSEL: if (wr_en && w_strb_q[0]) disp_d = w_data_q[7:0];
      lcs_pkg::ADDR_STATUS, lcs_pkg::ADDR_MONITOR, lcs_pkg::ADDR_FREQ: wr_hit = 1'b1;
      default: begin
        wr_hit = 1'b0;
        for (int i = 0; i < N_IN; i++) begin
          if (aw_addr_q == 8'(lcs_pkg::ADDR_INSEL + 8'(4 * (i / 4)))) begin
            wr_hit = 1'b1;
            if (wr_en && w_strb_q[i%4]) insel_d[i] = w_data_q[8*(i%4) +: 8];
          end
        end
        for (int i = 0; i < N_OUT; i++) begin
          if (aw_addr_q == 8'(lcs_pkg::ADDR_OUTSEL + 8'(4 * (i / 4)))) begin
            wr_hit = 1'b1;
            if (wr_en && w_strb_q[i%4]) outsel_d[i] = w_data_q[8*(i%4) +: 8];
          end
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Loop enable, switchover and arithmetic
  // ----------------------------------------------------------------
  always_comb begin
    assigned   = 1'b0;
    enable_lvl = 1'b0;
    for (int i = 0; i < N_IN; i++) begin
      if (insel_q[i] == lcs_pkg::FN_LOOP_EN) begin
        assigned   = 1'b1;
        enable_lvl = enable_lvl | in_pin[i] | fb_vterm[i];
      end
    end
    mode_dev  = (las_q == lcs_pkg::LAS_DEV_A) || (las_q == lcs_pkg::LAS_DEV_B);
    mode_spmv = (las_q == lcs_pkg::LAS_SPMV_A) || (las_q == lcs_pkg::LAS_SPMV_B);
    want      = (mode_dev || mode_spmv) && (!assigned || enable_lvl) && run;
    sw_on     = (sw_q != lcs_pkg::NO_FUNC) && (sw_q <= lcs_pkg::SW_MAX);
    state_d   = state_q;
    unique case (state_q)
      lcs_pkg::ST_IDLE:  if (want) state_d = sw_on ? lcs_pkg::ST_START : lcs_pkg::ST_LOOP;
      lcs_pkg::ST_START: begin
        if (!want) state_d = lcs_pkg::ST_IDLE;
        else if (!sw_on || (out_freq >= sw_q)) state_d = lcs_pkg::ST_LOOP;
      end
      lcs_pkg::ST_LOOP:  if (!want) state_d = lcs_pkg::ST_IDLE;
      default:           state_d = lcs_pkg::ST_IDLE;
    endcase
    if (mode_dev) dev = 17'(fb_deviation);
    else dev = $signed({1'b0, fb_set_point}) - $signed({1'b0, fb_measured});
    if (dev < 0) devc = 16'h0000;
    else if (dev > $signed({1'b0, lcs_pkg::FULL_DEV})) devc = lcs_pkg::FULL_DEV;
    else devc = 16'(dev);
    span   = $signed({1'b0, gain_q}) - $signed({1'b0, bias_q});
    quot   = (29'(span) * $signed({13'h0000, devc})) / lcs_pkg::FULL_DEV_W;
    freq_d = 16'(17'(bias_q) + 17'(quot));
    upper_lvl = mode_spmv && (upper_q != lcs_pkg::NO_FUNC) && (fb_measured > upper_q);
    lower_lvl = mode_spmv && (lower_q != lcs_pkg::NO_FUNC) && (fb_measured < lower_q);
    unique case (disp_q)
      lcs_pkg::MON_SP:  mon_d = fb_set_point;
      lcs_pkg::MON_MV:  mon_d = fb_measured;
      lcs_pkg::MON_DEV: mon_d = 16'(dev + $signed({1'b0, lcs_pkg::DEV_OFFSET}));
      default:          mon_d = 16'h0000;
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      las_q         <= lcs_pkg::LAS_OFF;
      disp_q        <= lcs_pkg::DISP_RST;
      upper_q       <= lcs_pkg::NO_FUNC;
      lower_q       <= lcs_pkg::NO_FUNC;
      sw_q          <= lcs_pkg::NO_FUNC;
      gain_q        <= lcs_pkg::GAIN_RST;
      bias_q        <= lcs_pkg::BIAS_RST;
      for (int i = 0; i < N_IN; i++) insel_q[i] <= lcs_pkg::SEL_NONE;
      for (int i = 0; i < N_OUT; i++) outsel_q[i] <= lcs_pkg::SEL_NONE;
      aw_have_q     <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_have_q      <= 1'b0;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= lcs_pkg::RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= lcs_pkg::RESP_OKAY;
      s_axi_rdata   <= 32'h0000_0000;
      state_q       <= lcs_pkg::ST_IDLE;
      loop_active_q <= 1'b0;
      freq_cmd_q    <= lcs_pkg::BIAS_RST;
      monitor_q     <= 16'h0000;
    end else begin
      las_q         <= las_d;
      disp_q        <= disp_d;
      upper_q       <= upper_d;
      lower_q       <= lower_d;
      sw_q          <= sw_d;
      gain_q        <= gain_d;
      bias_q        <= bias_d;
      insel_q       <= insel_d;
      outsel_q      <= outsel_d;
      aw_have_q     <= aw_have_d;
      aw_addr_q     <= aw_addr_d;
      w_have_q      <= w_have_d;
      w_data_q      <= w_data_d;
      w_strb_q      <= w_strb_d;
      s_axi_awready <= awready_d;
      s_axi_wready  <= wready_d;
      s_axi_bvalid  <= bvalid_d;
      s_axi_bresp   <= bresp_d;
      s_axi_arready <= arready_d;
      s_axi_rvalid  <= rvalid_d;
      s_axi_rresp   <= rresp_d;
      s_axi_rdata   <= rdata_d;
      state_q       <= state_d;
      loop_active_q <= (state_d == lcs_pkg::ST_LOOP);
      freq_cmd_q    <= freq_d;
      monitor_q     <= mon_d;
    end
  end

  // ----------------------------------------------------------------
  // Output terminals
  // ----------------------------------------------------------------
  for (genvar g = 0; g < N_OUT; g++) begin : g_out
    lcs_out_term u_term (
      .clock      (clock),
      .srst       (srst),
      .sel        (outsel_q[g]),
      .upper_lvl  (upper_lvl),
      .lower_lvl  (lower_lvl),
      .dir_lvl    (run && fwd),
      .active_lvl (state_q == lcs_pkg::ST_LOOP),
      .out_q      (out_term_q[g])
    );
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  sequence s_started_open;
    (state_q == lcs_pkg::ST_IDLE) && want && sw_on;
  endsequence

  AST_OFF_OPEN: assert property ((las_q == lcs_pkg::LAS_OFF) || (assigned && !enable_lvl)
    |=> !loop_active_q) else $error("Loop active while disabled.");
  AST_UNASSIGNED: assert property (!assigned && mode_dev && run && !sw_on
    |=> loop_active_q) else $error("Mode alone did not enable loop.");
  AST_PIN_ENABLE: assert property (assigned && enable_lvl && mode_spmv && run && !sw_on
    |=> loop_active_q) else $error("Enable terminal did not start loop.");
  AST_UPPER: assert property (upper_lvl && (outsel_q[0] == lcs_pkg::FN_UPPER)
    |=> out_term_q[0]) else $error("Upper flag missing.");
  AST_LOWER: assert property (mode_spmv && (lower_q != lcs_pkg::NO_FUNC) && (fb_measured < lower_q)
    && (outsel_q[0] == lcs_pkg::FN_LOWER) |=> out_term_q[0]) else $error("Lower flag missing.");
  AST_SWITCH_START: assert property (s_started_open |=> !loop_active_q ##0
    (state_q == lcs_pkg::ST_START)) else $error("Switchover start entered loop.");
  AST_STAY_LOOP: assert property (loop_active_q && want |=> loop_active_q)
    else $error("Loop left while still wanted.");
  AST_DEV_MON: assert property ((disp_q == lcs_pkg::MON_DEV) && (dev == 0)
    |=> (monitor_q == lcs_pkg::DEV_OFFSET)) else $error("Zero deviation monitor wrong.");
  AST_BIAS: assert property ((devc == 16'h0000) |=> (freq_cmd_q == $past(bias_q)))
    else $error("Bias frequency wrong.");
  AST_GAIN: assert property ((devc == lcs_pkg::FULL_DEV) |=> (freq_cmd_q == $past(gain_q)))
    else $error("Gain frequency wrong.");
endmodule : lcs_top
`default_nettype wire

// ---- verification/lcs_fb_model.sv ----
// Purpose: Fieldbus master model feeding the loop values.
// Assumes: Bench commands are levels.
// Notes:   Values reach the block one clock after a command.
`timescale 1ns/1ps
`default_nettype none
module lcs_fb_model (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        srst,
  // Commands
  input  wire logic [15:0] c_sp,
  input  wire logic [15:0] c_mv,
  input  wire logic [15:0] c_dev,
  input  wire logic [4:0]  c_vt,
  // Fieldbus values
  output logic [15:0]      sp_q,
  output logic [15:0]      mv_q,
  output logic [15:0]      dev_q,
  output logic [4:0]       vt_q
);
  // ----
  // Master registers
  // ----
  always_ff @(posedge clock) begin
    sp_q  <= srst ? 16'h0000 : c_sp;
    mv_q  <= srst ? 16'h0000 : c_mv;
    dev_q <= srst ? 16'h0000 : c_dev;
    vt_q  <= srst ? 5'h00 : c_vt;
  end
endmodule : lcs_fb_model
`default_nettype wire

// ---- verification/testbench.sv ----
// Purpose: Self-checking bench of the loop control supervisor.
// Assumes: Bias 10 Hz and gain 60 Hz during the random part.
// Notes:   Register access over AXI4-Lite tasks.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ----
  // Signals
  // ----
  logic        clock = 0, srst = 1, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
  logic        run = 0, fwd = 0, awr, wrd, bv, arr, rv, la;
  logic [7:0]  aw = 0, ar = 0;
  logic [31:0] wd = 0, rdt, r;
  logic [1:0]  br, rr;
  logic [15:0] sp = 0, mv = 0, dv = 0, of = 0, fsp, fmv, fdv, fc, mon, lf = 16'h000D;
  logic [4:0]  vt = 0, pin = 0, fvt;
  logic [5:0]  ot;
  int          bad_count = 0, checked = 0, vs, vm;
  always #12.5 clock = ~clock;
  lcs_fb_model i_lcs_fb_model (.clock(clock), .srst(srst), .c_sp(sp), .c_mv(mv), .c_dev(dv),
    .c_vt(vt), .sp_q(fsp), .mv_q(fmv), .dev_q(fdv), .vt_q(fvt));
  lcs_top i_lcs_top (.clock(clock), .srst(srst), .s_axi_awaddr(aw), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
    .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdt),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre), .fb_set_point(fsp),
    .fb_measured(fmv), .fb_deviation(fdv), .fb_vterm(fvt), .in_pin(pin), .run(run), .fwd(fwd),
    .out_freq(of), .out_term_q(ot), .loop_active_q(la), .freq_cmd_q(fc), .monitor_q(mon));
  // ----
  // Tasks
  // ----
  task complete_run;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run
  task chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  function logic [15:0] nx(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : nx
  function int fexp(input int d);
    return d <= 0 ? 1000 : d >= 1000 ? 6000 : 1000 + 5000 * d / 1000;
  endfunction : fexp
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    @(posedge clock);
    aw <= a;
    wd <= d;
    awv <= 1;
    wv <= 1;
    bre <= 1;
    do begin
      @(posedge clock);
      if (awr === 1'b1) awv <= 0;
      if (wrd === 1'b1) wv <= 0;
    end while (bv !== 1'b1);
    chk({bv, br}, {1'b1, e});
    bre <= 0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [1:0] e);
    @(posedge clock);
    ar <= a;
    arv <= 1;
    rre <= 1;
    do begin
      @(posedge clock);
      if (arr === 1'b1) arv <= 0;
    end while (rv !== 1'b1);
    r = rdt;
    chk({rv, rr}, {1'b1, e});
    rre <= 0;
  endtask : rd
  task st;
    repeat (3) @(posedge clock);
    #1;
  endtask : st
  // ----
  // Scenarios
  // ----
  initial begin
    repeat (4) @(posedge clock);
    srst <= 0;
    rd(lcs_pkg::ADDR_GAIN, lcs_pkg::RESP_OKAY); chk(r, 32'h1770);
    rd(lcs_pkg::ADDR_BIAS, lcs_pkg::RESP_OKAY); chk(r, 32'h0);
    rd(8'h38, lcs_pkg::RESP_SLVERR);
    wr(8'h38, 32'h0, lcs_pkg::RESP_SLVERR);
    wr(lcs_pkg::ADDR_OUTSEL, 32'h93100E0F, lcs_pkg::RESP_OKAY);
    wr(lcs_pkg::ADDR_UPPER, 32'd500, lcs_pkg::RESP_OKAY);
    wr(lcs_pkg::ADDR_LOWER, 32'd200, lcs_pkg::RESP_OKAY);
    wr(lcs_pkg::ADDR_BIAS, 32'd1000, lcs_pkg::RESP_OKAY);
    run <= 1;
    fwd <= 1;
    st;
    chk(ot, 6'h0C);
    chk(la, 1'b0);
    for (int i = 0; i < 8; i++) begin
      lf = nx(lf);
      vs = i == 0 ? 500 : i == 1 ? 1200 : lf % 1000;
      lf = nx(lf);
      vm = i == 0 ? 500 : i == 1 ? 200 : lf % 1000;
      wr(lcs_pkg::ADDR_MODE, i[0] ? 32'h3D : 32'h3C, lcs_pkg::RESP_OKAY);
      wr(lcs_pkg::ADDR_DISPSEL, 32'h34 + i % 3, lcs_pkg::RESP_OKAY);
      sp <= vs;
      mv <= vm;
      fwd <= i[0];
      st;
      chk(ot, {3'b000, i[0], vm < 200, vm > 500});
      chk(la, 1'b1);
      chk(fc, fexp(vs - vm));
      chk(mon, i % 3 == 0 ? vs : i % 3 == 1 ? vm : vs - vm + 1000);
    end
    wr(lcs_pkg::ADDR_MODE, 32'h32, lcs_pkg::RESP_OKAY);
    wr(lcs_pkg::ADDR_DISPSEL, 32'h36, lcs_pkg::RESP_OKAY);
    dv <= 16'h00FA;
    st;
    chk(mon, 1250);
    chk(fc, fexp(250));
    chk(ot[1:0], 2'b00);
    wr(lcs_pkg::ADDR_MODE, 32'h33, lcs_pkg::RESP_OKAY);
    dv <= 16'h03E8;
    st;
    chk(fc, 6000);
    chk(mon, 2000);
    wr(lcs_pkg::ADDR_INSEL, 32'h6363630E, lcs_pkg::RESP_OKAY);
    st;
    chk(la, 1'b0);
    @(posedge clock);
    vt <= 5'h01;
    st;
    chk(la, 1'b1);
    @(posedge clock);
    vt <= 5'h00;
    pin <= 5'h01;
    st;
    chk(la, 1'b1);
    @(posedge clock);
    pin <= 5'h00;
    st;
    chk(la, 1'b0);
    wr(lcs_pkg::ADDR_INSEL, 32'h63636363, lcs_pkg::RESP_OKAY);
    wr(lcs_pkg::ADDR_SWITCH, 32'h3E8, lcs_pkg::RESP_OKAY);
    run <= 0;
    of <= 16'h01F4;
    st;
    @(posedge clock);
    run <= 1;
    st;
    chk(la, 1'b0);
    @(posedge clock);
    of <= 16'h03E8;
    st;
    chk(la, 1'b1);
    @(posedge clock);
    of <= 16'h00C8;
    st;
    chk(la, 1'b1);
    chk(ot[3], 1'b0);
    complete_run;
  end
  initial begin
    repeat (20000) @(posedge clock);
    bad_count++;
    complete_run;
  end
endmodule : testbench
`default_nettype wire
